//--- spm_pkg.sv
// Shared constants and register map of the serial peripheral port
package spm_pkg;

  // ***************************************************************
  // Register byte offsets on the APB
  // ***************************************************************
  localparam logic [7:0] OFF_CONTROL = 8'h00;
  localparam logic [7:0] OFF_STATUS  = 8'h04;
  localparam logic [7:0] OFF_DATA    = 8'h08;
  localparam logic [7:0] OFF_DIVIDER = 8'h0c;

  // ***************************************************************
  // Field positions of serial_control_register
  // ***************************************************************
  localparam int CTL_PORT_EN   = 0;
  localparam int CTL_MASTER_EN = 1;
  localparam int CTL_SEL_LO    = 2;
  localparam int CTL_SEL_HI    = 3;
  localparam int CTL_IRQ_EN    = 4;

  // ***************************************************************
  // Field positions of the status register
  // ***************************************************************
  localparam int STS_DONE    = 0;
  localparam int STS_FAULT   = 1;
  localparam int STS_WRITE_COLLISION_FLAG    = 2;
  localparam int STS_OVERRUN = 3;
  localparam int STS_BUSY    = 4;
  localparam int STS_TX_FULL = 5;
  localparam int STS_RX_FULL = 6;

  // ***************************************************************
  // select_mode_field encodings and reset values
  // ***************************************************************
  localparam logic [1:0] SEL_3WIRE    = 2'h0;
  localparam logic [1:0] SEL_4W_INPUT = 2'h1;
  localparam logic [1:0] SEL_RESET    = 2'h1;
  localparam logic [7:0] DIV_RESET    = 8'h03;
  localparam logic [2:0] LAST_BIT     = 3'h7;
  localparam int         SYNC_WIDTH   = 4;

  // Index of each pin in the synchroniser vector
  localparam int PIN_SCLK = 0;
  localparam int PIN_MOSI = 1;
  localparam int PIN_MISO = 2;
  localparam int PIN_NSS  = 3;

endpackage

//--- spm_sync.sv
// Two-flop synchroniser for the serial pins
`timescale 1ns/100ps
`default_nettype none
module spm_sync (
  input  wire logic                           clock,
  input  wire logic                           rst_n,
  input  wire logic [spm_pkg::SYNC_WIDTH-1:0] async_in,
  output logic      [spm_pkg::SYNC_WIDTH-1:0] sync_out
);
  import spm_pkg::*;

  typedef struct packed {
    logic [SYNC_WIDTH-1:0] meta;
    logic [SYNC_WIDTH-1:0] stable;
  } spm_sync_t;

  spm_sync_t st;
  spm_sync_t next_st;

  // Meta stage feeds only the stable stage
  always_comb begin
    next_st.meta   = async_in;
    next_st.stable = st.meta;
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign sync_out = st.stable;
endmodule // spm_sync
`default_nettype wire

//--- spm_clkdiv.sv
// Serial clock rate divider: one tick per half period
`timescale 1ns/100ps
`default_nettype none
module spm_clkdiv (
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic       run,
  input  wire logic [7:0] divide,
  output logic            tick
);
  import spm_pkg::*;

  typedef struct packed {
    logic [7:0] count;
    logic       tick;
  } spm_div_t;

  spm_div_t st;
  spm_div_t next_st;

  // Half period is divide+1 system clocks
  always_comb begin
    next_st = st;
    next_st.tick = 1'b0;
    if (!run) begin
      next_st.count = '0;
    end else if (st.count >= divide) begin
      next_st.count = '0;
      next_st.tick  = 1'b1;
    end else begin
      next_st.count = st.count + 8'h01;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tick = st.tick;
endmodule // spm_clkdiv
`default_nettype wire

//--- spm_top.sv
// Serial peripheral port, master or slave, with APB register access
// How it works
// - Master drives outgoing data from shift register MSB, MSB first.
// - Slave data output floats when disabled or unselected 4-wire slave.
// - 3-wire slave always drives slave output from shift register MSB.
// - Unselected 4-wire slave ignores all serial clock activity.
// - Select mode 00 is 3-wire; slave counts as always selected.
// - Mode 01: select is input; low level selects slave, low level disables master.
// - Mode 1x: select is output carrying the mode field low bit.
// - Select pin routed in every mode except 3-wire.
// - Master enable bit makes the port master; only masters start transfers.
// - Master data write loads transmit buffer, moves to idle shifter, starts.
// - Byte end sets transfer-done flag, interrupting when enabled.
// - Master shifts incoming bits MSB first, full byte goes to receive buffer.
// - Multi-master low select clears enables until re-enabled, sets mode fault until written one.
// - Select mode high bit set means 4-wire single master, select output.
// - Slave counts clock edges; eight bits set done and fill receive buffer.
// - Write while transmit buffer full is dropped and sets write collision.
// - Slave byte ending on unread receive buffer sets overrun, keeps old.
`timescale 1ns/100ps
`default_nettype none
module spm_top (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic      [31:0] prdata,
  output logic             pslverr,
  input  wire logic        sclk_in,
  output logic             sclk_out,
  output logic             sclk_oe_n,
  input  wire logic        mosi_in,
  output logic             mosi_out,
  output logic             mosi_oe_n,
  input  wire logic        miso_in,
  output logic             miso_out,
  output logic             miso_oe_n,
  input  wire logic        nss_in,
  output logic             nss_out,
  output logic             nss_oe_n,
  output logic             nss_routed,
  output logic             irq
);
  import spm_pkg::*;

  // ***************************************************************
  // State
  // ***************************************************************
  typedef struct packed {
    logic        port_en;
    logic        master_en;
    logic        irq_en;
    logic [1:0]  sel_mode;
    logic [7:0]  divide;
    logic        done_f;
    logic        fault_f;
    logic        write_collision_flag_f;
    logic        ovr_f;
    logic [7:0]  txbuf;
    logic        tx_full;
    logic [7:0]  rxbuf;
    logic        rx_full;
    logic [7:0]  shift;
    logic        loaded;
    logic        busy;
    logic [2:0]  bitcnt;
    logic        cap;
    logic        sclk_prev;
    logic        nss_prev;
    logic        sclk_out;
    logic        sclk_oe_n;
    logic        mosi_out;
    logic        mosi_oe_n;
    logic        miso_out;
    logic        miso_oe_n;
    logic        nss_out;
    logic        nss_oe_n;
    logic        nss_routed;
    logic        irq;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } spm_state_t;

  localparam spm_state_t ST_RESET = '{sel_mode: SEL_RESET, divide: DIV_RESET, sclk_oe_n: 1'b1,
                                      mosi_oe_n: 1'b1, miso_oe_n: 1'b1, nss_oe_n: 1'b1,
                                      nss_routed: 1'b1, default: '0};

  spm_state_t st;
  spm_state_t next_st;

  logic [SYNC_WIDTH-1:0] pins_s;
  logic                  tick;

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
    hit = (addr == off);
  endfunction

  // ***************************************************************
  // Pin synchroniser and master clock divider
  // ***************************************************************
  spm_sync u_sync (
    .clock    (clock),
    .rst_n    (rst_n),
    .async_in ({nss_in, miso_in, mosi_in, sclk_in}),
    .sync_out (pins_s)
  );

  spm_clkdiv u_div (
    .clock  (clock),
    .rst_n  (rst_n),
    .run    (st.port_en & st.master_en & st.busy),
    .divide (st.divide),
    .tick   (tick)
  );

  // ***************************************************************
  // Next state
  // ***************************************************************
  always_comb begin
    logic       sclk_s;
    logic       nss_s;
    logic       is_master;
    logic       selected;
    logic       slave_act;
    logic       rise;
    logic       fall;
    logic       din;
    logic       wr;
    logic       rd;
    logic       rd_data;
    logic       mapped;
    logic [7:0] rx_byte;
    logic [31:0] rmux;
    sclk_s    = pins_s[PIN_SCLK];
    nss_s     = pins_s[PIN_NSS];
    is_master = st.port_en & st.master_en;
    // Mode 00 always selected, mode 01 selected by low level, output modes never
    selected  = (st.sel_mode == SEL_3WIRE) | ((st.sel_mode == SEL_4W_INPUT) & ~nss_s);
    slave_act = st.port_en & ~st.master_en & selected;
    rise      = (is_master & st.busy & tick & ~st.sclk_out) | (slave_act & sclk_s & ~st.sclk_prev);
    fall      = (is_master & st.busy & tick & st.sclk_out) | (slave_act & ~sclk_s & st.sclk_prev);
    din       = is_master ? pins_s[PIN_MISO] : pins_s[PIN_MOSI];
    rx_byte   = {st.shift[6:0], st.cap};
    wr        = psel & penable & st.pready & pwrite;
    rd        = psel & penable & st.pready & ~pwrite;
    rd_data   = rd & hit(paddr, OFF_DATA);
    mapped    = hit(paddr, OFF_CONTROL) | hit(paddr, OFF_STATUS) | hit(paddr, OFF_DATA) | hit(paddr, OFF_DIVIDER);
    rmux      = '0;

    next_st = st;
    next_st.sclk_prev = sclk_s;
    next_st.nss_prev  = nss_s;

    // ***************************************************************
    // Register writes first, so hardware sets below win over clears
    // ***************************************************************
    if (wr && hit(paddr, OFF_CONTROL)) begin
      next_st.port_en   = pwdata[CTL_PORT_EN];
      next_st.master_en = pwdata[CTL_MASTER_EN];
      next_st.sel_mode  = pwdata[CTL_SEL_HI:CTL_SEL_LO];
      next_st.irq_en    = pwdata[CTL_IRQ_EN];
    end
    if (wr && hit(paddr, OFF_STATUS)) begin
      // Write one to clear; the only way these flags fall
      if (pwdata[STS_DONE])    next_st.done_f  = 1'b0;
      if (pwdata[STS_FAULT])   next_st.fault_f = 1'b0;
      if (pwdata[STS_WRITE_COLLISION_FLAG])    next_st.write_collision_flag_f  = 1'b0;
      if (pwdata[STS_OVERRUN]) next_st.ovr_f   = 1'b0;
    end
    if (wr && hit(paddr, OFF_DIVIDER)) begin
      next_st.divide = pwdata[7:0];
    end
    if (wr && hit(paddr, OFF_DATA)) begin
      if (st.tx_full) begin
        next_st.write_collision_flag_f = 1'b1;
      end else begin
        next_st.txbuf   = pwdata[7:0];
        next_st.tx_full = 1'b1;
      end
    end
    if (rd_data) begin
      next_st.rx_full = 1'b0;
    end

    // ***************************************************************
    // Shifting: sample on rising edge, shift on falling edge
    // ***************************************************************
    if ((st.sel_mode == SEL_4W_INPUT) && !st.master_en && st.nss_prev && !nss_s) begin
      next_st.bitcnt = '0;
    end
    if (rise) begin
      next_st.cap = din;
      if (is_master) next_st.sclk_out = 1'b1;
    end
    if (fall) begin
      next_st.shift  = rx_byte;
      next_st.bitcnt = st.bitcnt + 3'h1;
      if (is_master) next_st.sclk_out = 1'b0;
      if (st.bitcnt == LAST_BIT) begin
        next_st.done_f = 1'b1;
        next_st.busy   = 1'b0;
        next_st.loaded = 1'b0;
        // A read in this same cycle frees the buffer for the new byte
        if (!is_master && st.rx_full && !rd_data) begin
          next_st.ovr_f = 1'b1;
        end else begin
          next_st.rxbuf   = rx_byte;
          next_st.rx_full = 1'b1;
        end
      end
    end

    // Empty shifter takes the pending byte; master starts at once
    if (st.port_en && st.tx_full && !st.loaded && !st.busy && st.bitcnt == '0 && !fall) begin
      next_st.shift   = st.txbuf;
      next_st.tx_full = 1'b0;
      next_st.loaded  = 1'b1;
      next_st.busy    = is_master;
    end

    // ***************************************************************
    // Mode fault and disable
    // ***************************************************************
    if (is_master && st.sel_mode == SEL_4W_INPUT && !nss_s) begin
      next_st.master_en = 1'b0;
      next_st.port_en   = 1'b0;
      next_st.fault_f   = 1'b1;
    end
    // Disabling is the only reset of a 3-wire slave bit counter
    if (!st.port_en) begin
      next_st.bitcnt   = '0;
      next_st.busy     = 1'b0;
      next_st.sclk_out = 1'b0;
    end
    if (!(next_st.port_en & next_st.master_en)) begin
      next_st.sclk_out = 1'b0;
    end

    // ***************************************************************
    // Pin outputs, all registered
    // ***************************************************************
    next_st.mosi_out   = next_st.shift[7];
    next_st.mosi_oe_n  = ~(next_st.port_en & next_st.master_en);
    next_st.sclk_oe_n  = ~(next_st.port_en & next_st.master_en);
    next_st.miso_out   = next_st.shift[7];
    next_st.miso_oe_n  = ~(next_st.port_en & ~next_st.master_en & selected);
    next_st.nss_out    = next_st.sel_mode[0];
    next_st.nss_oe_n   = ~next_st.sel_mode[1];
    next_st.nss_routed = (next_st.sel_mode != SEL_3WIRE);
    next_st.irq        = next_st.irq_en & (next_st.done_f | next_st.fault_f |
                                           next_st.write_collision_flag_f | next_st.ovr_f);

    // ***************************************************************
    // APB answer: zero wait states, data captured in setup cycle
    // ***************************************************************
    if (hit(paddr, OFF_CONTROL)) begin
      rmux[CTL_PORT_EN]           = st.port_en;
      rmux[CTL_MASTER_EN]         = st.master_en;
      rmux[CTL_SEL_HI:CTL_SEL_LO] = st.sel_mode;
      rmux[CTL_IRQ_EN]            = st.irq_en;
    end else if (hit(paddr, OFF_STATUS)) begin
      rmux[STS_DONE]    = st.done_f;
      rmux[STS_FAULT]   = st.fault_f;
      rmux[STS_WRITE_COLLISION_FLAG]    = st.write_collision_flag_f;
      rmux[STS_OVERRUN] = st.ovr_f;
      rmux[STS_BUSY]    = st.busy | (st.bitcnt != '0);
      rmux[STS_TX_FULL] = st.tx_full;
      rmux[STS_RX_FULL] = st.rx_full;
    end else if (hit(paddr, OFF_DATA)) begin
      rmux[7:0] = st.rxbuf;
    end else if (hit(paddr, OFF_DIVIDER)) begin
      rmux[7:0] = st.divide;
    end
    next_st.pready  = psel & ~penable;
    next_st.pslverr = psel & ~penable & ~mapped;
    next_st.prdata  = (psel & ~penable & ~pwrite) ? rmux : '0;
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      st <= ST_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign pready     = st.pready;
  assign prdata     = st.prdata;
  assign pslverr    = st.pslverr;
  assign sclk_out   = st.sclk_out;
  assign sclk_oe_n  = st.sclk_oe_n;
  assign mosi_out   = st.mosi_out;
  assign mosi_oe_n  = st.mosi_oe_n;
  assign miso_out   = st.miso_out;
  assign miso_oe_n  = st.miso_oe_n;
  assign nss_out    = st.nss_out;
  assign nss_oe_n   = st.nss_oe_n;
  assign nss_routed = st.nss_routed;
  assign irq        = st.irq;
endmodule // spm_top
`default_nettype wire

//--- spm_peer.sv
// Behavioural far-side slave for the master role of the serial port
`timescale 1ns/100ps
`default_nettype none
module spm_peer (
  input  wire logic       sclk,
  input  wire logic       mosi,
  input  wire logic       sel_n,
  input  wire logic       ld,
  input  wire logic [7:0] tx,
  output logic            miso,
  output logic      [7:0] got
);
  // ****************
  // Shifting
  // ****************
  logic [7:0] sh = 8'h00;
  logic [7:0] rx = 8'h00;
  logic [2:0] rc = 3'h0;
  logic [2:0] fc = 3'h0;
  // Sole slave on the bus; deselected line shows the inverse
  assign miso = sel_n ? ~sh[7] : sh[7];
  always @(posedge sclk) begin
    if (!sel_n) begin
      rx <= {rx[6:0], mosi};
      rc <= rc + 3'h1;
      if (rc == 3'h7) got <= {rx[6:0], mosi};
    end
  end
  // Next byte reloads at the eighth fall, as a real slave would
  always @(negedge sclk or posedge ld) begin
    if (ld) begin
      sh <= tx;
      fc <= 3'h0;
    end else if (!sel_n) begin
      fc <= fc + 3'h1;
      sh <= (fc == 3'h7) ? tx : {sh[6:0], 1'b0};
    end
  end
endmodule // spm_peer
`default_nettype wire

//--- spm_top_sva.sv
// Pin and APB checker bound to the serial port top
`timescale 1ns/100ps
`default_nettype none
module spm_chk (
  input wire logic       clock,
  input wire logic       rst_n,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic [7:0] paddr,
  input wire logic       pready,
  input wire logic       pslverr,
  input wire logic       sclk_out,
  input wire logic       sclk_oe_n,
  input wire logic       mosi_out,
  input wire logic       mosi_oe_n,
  input wire logic       miso_oe_n,
  input wire logic       nss_in,
  input wire logic       nss_oe_n,
  input wire logic       nss_routed
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // ****************
  // Relations
  // ****************
  a_pready_after_setup: assert property (
    psel && !penable |=> pready) else $error("no answer after setup");
  a_pready_one_cycle: assert property (
    pready |=> !pready) else $error("pready held");
  a_slverr_map: assert property (
    pready |-> pslverr == !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0c})) else $error("bad slverr");
  a_miso_slave_only: assert property (
    !miso_oe_n |-> sclk_oe_n && mosi_oe_n && nss_oe_n) else $error("miso driven off slave role");
  a_route_three_wire: assert property (
    !nss_routed |-> nss_oe_n) else $error("select driven while unrouted");
  a_nss_out_routed: assert property (
    !nss_oe_n |-> nss_routed && !mosi_oe_n) else $error("select output off master");
  a_fault_release: assert property (
    !sclk_oe_n && nss_routed && nss_oe_n && !nss_in |-> ##[1:6] sclk_oe_n) else $error("no mode fault");
  a_mosi_low_phase: assert property (
    !mosi_oe_n && $changed(mosi_out) |-> !sclk_out) else $error("mosi moved with sclk high");
endmodule // spm_chk
bind spm_top spm_chk u_chk (.clock, .rst_n, .psel, .penable, .paddr, .pready, .pslverr, .sclk_out,
  .sclk_oe_n, .mosi_out, .mosi_oe_n, .miso_oe_n, .nss_in, .nss_oe_n, .nss_routed);
`default_nettype wire

//--- spm_top_tb_top.sv
// Self-checking bench of the serial port over APB and pins
`timescale 1ns/100ps
`default_nettype none
`define CK(a, e) begin checks++; if ((a) !== (e)) begin fails++; $display("ERROR %0t bad value %h", $time, a); end end
module spm_top_tb_top;
  import spm_pkg::*;
  logic        clock = 0;
  logic        rst_n = 0;
  logic        psel = 0;
  logic        penable = 0;
  logic        pwrite = 0;
  logic [7:0]  paddr = 0;
  logic [31:0] pwdata = 0;
  logic        pready, pslverr, irq, perr;
  logic [31:0] prdata, s;
  logic        sclk_out, sclk_oe_n, mosi_out, mosi_oe_n, miso_out, miso_oe_n, nss_out, nss_oe_n, nss_routed;
  logic        t_sclk = 0;
  logic        t_mosi = 0;
  logic        t_nss = 1;
  logic        p_ld = 0;
  logic [7:0]  p_tx = 0;
  logic [7:0]  p_got, g;
  wire         p_miso;
  int          fails = 0;
  int          checks = 0;
  int          n;
  // Each wire resolved from whichever side drives it
  wire sclk_in = sclk_oe_n ? t_sclk : sclk_out;
  wire mosi_in = mosi_oe_n ? t_mosi : mosi_out;
  wire miso_in = miso_oe_n ? p_miso : miso_out;
  wire nss_in = nss_oe_n ? t_nss : nss_out;
  wire p_sel_n = nss_oe_n ? 1'b0 : nss_out;
  spm_top uut (.clock, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
    .sclk_in, .sclk_out, .sclk_oe_n, .mosi_in, .mosi_out, .mosi_oe_n, .miso_in, .miso_out, .miso_oe_n,
    .nss_in, .nss_out, .nss_oe_n, .nss_routed, .irq);
  spm_peer u_peer (.sclk(sclk_out), .mosi(mosi_out), .sel_n(p_sel_n), .ld(p_ld), .tx(p_tx),
    .miso(p_miso), .got(p_got));
  // ****************
  // Bus and link tasks
  // ****************
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1;
    do @(posedge clock); while (pready !== 1'b1);
    s = prdata;
    perr = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge clock);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    xfer(0, a, 0);
  endtask
  task automatic wdone;
    s = 0;
    for (int i = 0; i < 60 && s[STS_DONE] !== 1'b1; i++) rd(OFF_STATUS);
  endtask
  // Link clock of 200 ns made by the bench in the master's place
  task automatic xb(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      t_mosi <= b[i];
      repeat (4) @(posedge clock);
      t_sclk <= 1;
      g[i] = miso_in;
      repeat (4) @(posedge clock);
      t_sclk <= 0;
    end
    repeat (8) @(posedge clock);
  endtask
  task automatic complete_run;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial forever #12.5 clock = ~clock;
  initial begin
    repeat (20000) @(posedge clock);
    fails++;
    complete_run;
  end
  // ****************
  // Tests
  // ****************
  initial begin
    repeat (8) @(posedge clock);
    rst_n <= 1;
    @(posedge clock);
    `CK({sclk_oe_n, mosi_oe_n, miso_oe_n, nss_oe_n, nss_routed}, 5'h1f)
    rd(OFF_CONTROL); `CK(s, 32'h4)
    rd(OFF_DIVIDER); `CK(s, 32'h3)
    rd(OFF_STATUS); `CK(s, 32'h0)
    rd(8'h10); `CK({perr, s}, 33'h100000000)
    $display("reset test done");
    wr(OFF_CONTROL, 32'h1f); `CK({nss_oe_n, nss_out}, 2'h1)
    wr(OFF_CONTROL, 32'h1b); `CK({nss_oe_n, nss_out, nss_routed}, 3'h1)
    wr(OFF_DIVIDER, 32'h4);
    p_tx <= 8'h3c;
    p_ld <= 1;
    @(posedge clock);
    p_ld <= 0;
    p_tx <= 8'hc3;
    wr(OFF_DATA, 32'ha5);
    wr(OFF_DATA, 32'h5a);
    wr(OFF_DATA, 32'hff);
    wdone;
    `CK(p_got, 8'ha5)
    rd(OFF_DATA); `CK(s, 32'h3c)
    rd(OFF_STATUS); `CK({s[STS_WRITE_COLLISION_FLAG], s[STS_DONE], irq}, 3'h7)
    wr(OFF_STATUS, 32'hf);
    for (n = 0; n < 99 && sclk_out !== 1'b0; n++) @(posedge clock);
    for (n = 0; n < 99 && sclk_out !== 1'b1; n++) @(posedge clock);
    for (n = 0; n < 99 && sclk_out === 1'b1; n++) @(posedge clock);
    `CK(n, 5)
    wdone;
    `CK(p_got, 8'h5a)
    rd(OFF_DATA); `CK(s, 32'hc3)
    rd(OFF_STATUS); `CK(s[STS_BUSY], 1'b0)
    wr(OFF_STATUS, 32'hf); `CK(irq, 1'b0)
    $display("master test done");
    // Settle the select input first; a stale low from output mode would fault at once
    wr(OFF_CONTROL, 32'h4);
    wr(OFF_CONTROL, 32'h7);
    rd(OFF_CONTROL); `CK(s, 32'h7)
    t_nss <= 0;
    repeat (8) @(posedge clock);
    rd(OFF_CONTROL); `CK(s, 32'h4)
    rd(OFF_STATUS); `CK(s[STS_FAULT], 1'b1)
    t_nss <= 1;
    repeat (4) @(posedge clock);
    rd(OFF_CONTROL); `CK(s, 32'h4)
    wr(OFF_STATUS, 32'hf);
    $display("fault test done");
    wr(OFF_CONTROL, 32'h5);
    wr(OFF_DATA, 32'h96);
    xb(8'hff);
    rd(OFF_STATUS); `CK({s[STS_DONE], miso_oe_n}, 2'h1)
    t_nss <= 0;
    repeat (6) @(posedge clock);
    `CK(miso_oe_n, 1'b0)
    xb(8'h69); `CK(g, 8'h96)
    rd(OFF_STATUS); `CK(s[STS_DONE], 1'b1)
    xb(8'h11);
    rd(OFF_STATUS); `CK(s[STS_OVERRUN], 1'b1)
    rd(OFF_DATA); `CK(s, 32'h69)
    t_nss <= 1;
    wr(OFF_CONTROL, 32'h1);
    `CK({nss_routed, miso_oe_n}, 2'h0)
    wr(OFF_DATA, 32'he7);
    xb(8'h3c); `CK(g, 8'he7)
    rd(OFF_DATA); `CK(s, 32'h3c)
    wr(OFF_CONTROL, 32'h0); `CK(miso_oe_n, 1'b1)
    $display("slave test done");
    complete_run;
  end
endmodule // spm_top_tb_top
`default_nettype wire
